// File: hw/lsh_ctl.sv
// controller end: routes software accesses to the network or local host side
`timescale 1ns/1ps
module lsh_ctl
   import lsh_pkg::*;
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 nrst_i,
   input  wire logic [SW_ADDR_W-1:0] sw_addr_i,
   input  wire logic [DATA_W-1:0]    sw_wdata_i,
   input  wire logic                 sw_wr_i,
   input  wire logic                 sw_rd_i,
   output logic      [DATA_W-1:0]    sw_rdata_o,
   output logic                      refused_o,
   lsh_if.ctl                        bus
);
   logic [1:0]        sel;
   logic [1:0]        rd_sel;
   logic              rd_pend;
   logic              refused;
   logic [DATA_W-1:0] ctl_rdata;
   logic [1:0]        next_rd_sel;
   logic              next_rd_pend;
   logic              next_refused;
   logic [DATA_W-1:0] next_ctl_rdata;
   logic              ctl_hit;

   assign sel = sw_addr_i[SW_ADDR_W-1:ADDR_W];

   // a network write the device does not take shows as a refusal
   always_comb begin
      ctl_hit        = sel == SEL_CTL && sw_addr_i[ADDR_W-1:0] == CTL_OFF_STAT;
      next_rd_sel    = sel;
      next_rd_pend   = sw_rd_i;
      next_refused   = refused;
      next_ctl_rdata = 8'h00;
      if (sw_wr_i && ctl_hit && sw_wdata_i[CTL_REFUSED]) begin
         next_refused = 1'b0;
      end
      if (sw_wr_i && sel == SEL_NET && !bus.net_wr_taken) begin
         next_refused = 1'b1; // R11
      end
      if (sw_rd_i && ctl_hit) begin
         next_ctl_rdata[CTL_REFUSED] = refused;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_sel    <= SEL_NET;
         rd_pend   <= 1'b0;
         refused   <= 1'b0;
         ctl_rdata <= 8'h00;
      end else begin
         rd_sel    <= next_rd_sel;
         rd_pend   <= next_rd_pend;
         refused   <= next_refused;
         ctl_rdata <= next_ctl_rdata;
      end
   end

   assign bus.net_addr  = sw_addr_i[ADDR_W-1:0];
   assign bus.net_wdata = sw_wdata_i;
   assign bus.net_wr    = sw_wr_i && sel == SEL_NET; // R9 R10
   assign bus.net_rd    = sw_rd_i && sel == SEL_NET;
   assign bus.hst_addr  = sw_addr_i[ADDR_W-1:0];
   assign bus.hst_wdata = sw_wdata_i;
   // host writes status only with mirroring off; device ignores them otherwise
   assign bus.hst_wr    = sw_wr_i && sel == SEL_HST; // R16 R18
   assign bus.hst_rd    = sw_rd_i && sel == SEL_HST; // R13

   always_comb begin
      sw_rdata_o = 8'h00;
      if (rd_pend) begin
         unique case (rd_sel)
            SEL_NET: sw_rdata_o = bus.net_rdata;
            SEL_HST: sw_rdata_o = bus.hst_rdata;
            SEL_CTL: sw_rdata_o = ctl_rdata;
            default: sw_rdata_o = 8'h00;
         endcase
      end
   end

   assign refused_o = refused;
endmodule // lsh_ctl

// File: hw/lsh_dev.sv
// link-status and state handshake register bank of the subordinate controller
// Summary of operation
// R1 - per-port physical link flags at bits 4-6
// R2 - per-port stable communication flags at 9,11,13
// R3 - per-port loop closed flags at 8,10,12
// R4 - bit 2 enhanced link, taken at first load
// R5 - bit 1 shows host watchdog reloaded
// R6 - bit 0 host ok, gates process data access
// R7 - network read of link word clears event
// R8 - multi-byte registers little-endian by address
// R9 - state request field codes, reset to init
// R10 - request bit 4 acknowledges error flag
// R11 - mirroring off: lock until host reads
// R12 - after reset request register is writable
// R13 - host read of either byte unlocks
// R14 - mirroring on: accept and copy to status
// R15 - host read of request clears host events
// R16 - status read-only from network, host-writable
// R17 - actual state field codes, reset to init
// R18 - status bit 4 is the error flag
// R19 - network read of status clears its event
// R20 - status code word, host-writable, reset zero
// R21 - mirroring on: host status writes ignored
`timescale 1ns/1ps
module lsh_dev
   import lsh_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   lsh_if.dev              bus,
   input  wire logic [2:0] phy_link_i,
   input  wire logic [2:0] comm_ok_i,
   input  wire logic [2:0] loop_closed_i,
   input  wire logic       wdog_reloaded_i,
   input  wire logic       cfg_loaded_ok_i,
   input  wire logic       host_if_ok_i,
   input  wire logic       cfg_load_done_i,
   input  wire logic       enh_link_cfg_i,
   input  wire logic       mirror_en_i,
   output logic [3:0]      req_state_o,
   output logic            err_ack_o,
   output logic            req_locked_o,
   output logic [3:0]      act_state_o,
   output logic            err_ind_o,
   output logic [15:0]     status_code_o,
   output logic            pd_access_en_o,
   output logic            link_evt_clr_o,
   output logic            state_evt_clr_o,
   output logic            host_evt_clr_o
);
   logic [NPORT-1:0]  phy_s;
   logic [NPORT-1:0]  comm_s;
   logic [NPORT-1:0]  loop_s;
   logic [15:0]       link_word;

   logic [ST_W-1:0]   req;
   logic [ST_W-1:0]   stat;
   logic [15:0]       code;
   logic              locked;
   logic              enh;
   logic              enh_taken;
   logic [DATA_W-1:0] net_rdata;
   logic [DATA_W-1:0] hst_rdata;
   logic              link_clr;
   logic              state_clr;
   logic              host_clr;

   logic [ST_W-1:0]   next_req;
   logic [ST_W-1:0]   next_stat;
   logic [15:0]       next_code;
   logic              next_locked;
   logic              next_enh;
   logic              next_enh_taken;
   logic [DATA_W-1:0] next_net_rdata;
   logic [DATA_W-1:0] next_hst_rdata;
   logic              next_link_clr;
   logic              next_state_clr;
   logic              next_host_clr;
   logic              net_req_hit;
   logic              req_accept;
   logic              hst_req_read;

   // link pins come from the port logic outside this clock
   lsh_sync3 #(.W(3 * NPORT)) u_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     ({loop_closed_i, comm_ok_i, phy_link_i}),
      .level_o   ({loop_s, comm_s, phy_s})
   );

   always_comb begin
      link_word              = 16'h0000;
      link_word[LNK_HOST_OK] = cfg_loaded_ok_i & host_if_ok_i; // R6
      link_word[LNK_WDOG]    = wdog_reloaded_i;                // R5
      link_word[LNK_ENH]     = enh;                            // R4
      for (int p = 0; p < NPORT; p++) begin
         link_word[LNK_PHY0 + p]               = phy_s[p];  // R1
         link_word[LNK_LOOP0 + LNK_STRIDE * p] = loop_s[p]; // R3
         link_word[LNK_COMM0 + LNK_STRIDE * p] = comm_s[p]; // R2
      end
   end

   // both sides see the same byte at a given offset
   function automatic logic [DATA_W-1:0] rd_byte(input logic [ADDR_W-1:0] a,
                                                 input logic [15:0] lw,
                                                 input logic [ST_W-1:0] rq,
                                                 input logic [ST_W-1:0] st,
                                                 input logic [15:0] cd);
      logic [DATA_W-1:0] d;
      d = 8'h00;
      unique case (a)
         OFF_LINK_LO: d = lw[7:0];  // R8
         OFF_LINK_HI: d = lw[15:8]; // R8
         OFF_REQ_LO:  d = {3'h0, rq};
         OFF_STAT_LO: d = {3'h0, st};
         OFF_CODE_LO: d = cd[7:0];  // R8
         OFF_CODE_HI: d = cd[15:8]; // R8
         default:     d = 8'h00;
      endcase
      return d;
   endfunction

   always_comb begin
      next_req       = req;
      next_stat      = stat;
      next_code      = code;
      next_locked    = locked;
      next_enh       = enh;
      next_enh_taken = enh_taken;

      net_req_hit  = bus.net_wr && (bus.net_addr == OFF_REQ_LO || bus.net_addr == OFF_REQ_HI);
      req_accept   = net_req_hit && (mirror_en_i || !locked);                        // R11 R14
      hst_req_read = bus.hst_rd && (bus.hst_addr == OFF_REQ_LO || bus.hst_addr == OFF_REQ_HI);

      // host side of the state-request register only reads it
      if (req_accept && bus.net_addr == OFF_REQ_LO) begin
         next_req = bus.net_wdata[ST_W-1:0]; // R9 R10
      end
      if (hst_req_read) begin
         next_locked = 1'b0; // R13
      end
      // a new network write in the same cycle keeps the lock
      if (req_accept && !mirror_en_i) begin
         next_locked = 1'b1; // R11
      end

      if (mirror_en_i) begin
         if (req_accept) begin
            next_stat = next_req; // R14
         end
      end else if (bus.hst_wr && bus.hst_addr == OFF_STAT_LO) begin
         next_stat = bus.hst_wdata[ST_W-1:0]; // R16 R17 R18
      end // host status writes dropped under mirroring R21

      if (bus.hst_wr && bus.hst_addr == OFF_CODE_LO) begin
         next_code[7:0] = bus.hst_wdata; // R20
      end
      if (bus.hst_wr && bus.hst_addr == OFF_CODE_HI) begin
         next_code[15:8] = bus.hst_wdata; // R20
      end

      // later configuration loads never change this bit
      if (cfg_load_done_i && !enh_taken) begin
         next_enh       = enh_link_cfg_i; // R4
         next_enh_taken = 1'b1;
      end

      next_net_rdata = bus.net_rd ? rd_byte(bus.net_addr, link_word, req, stat, code) : 8'h00;
      next_hst_rdata = bus.hst_rd ? rd_byte(bus.hst_addr, link_word, req, stat, code) : 8'h00;
      next_link_clr  = bus.net_rd &&
                       (bus.net_addr == OFF_LINK_LO || bus.net_addr == OFF_LINK_HI); // R7
      next_state_clr = bus.net_rd &&
                       (bus.net_addr == OFF_STAT_LO || bus.net_addr == OFF_STAT_HI); // R19
      next_host_clr  = hst_req_read;                                                // R15
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req       <= REQ_RST;  // R9 R10
         stat      <= STAT_RST; // R17
         code      <= CODE_RST; // R20
         locked    <= 1'b0;     // R12
         enh       <= 1'b0;     // R4
         enh_taken <= 1'b0;
         net_rdata <= 8'h00;
         hst_rdata <= 8'h00;
         link_clr  <= 1'b0;
         state_clr <= 1'b0;
         host_clr  <= 1'b0;
      end else begin
         req       <= next_req;
         stat      <= next_stat;
         code      <= next_code;
         locked    <= next_locked;
         enh       <= next_enh;
         enh_taken <= next_enh_taken;
         net_rdata <= next_net_rdata;
         hst_rdata <= next_hst_rdata;
         link_clr  <= next_link_clr;
         state_clr <= next_state_clr;
         host_clr  <= next_host_clr;
      end
   end

   // network side cannot write anything else in this range
   assign bus.net_wr_taken = req_accept;
   assign bus.net_rdata    = net_rdata;
   assign bus.hst_rdata    = hst_rdata;
   assign req_state_o      = req[3:0];
   assign err_ack_o        = req[ST_FLAG];
   assign req_locked_o     = locked;
   assign act_state_o      = stat[3:0];
   assign err_ind_o        = stat[ST_FLAG];
   assign status_code_o    = code;
   assign pd_access_en_o   = link_word[LNK_HOST_OK]; // R6
   assign link_evt_clr_o   = link_clr;
   assign state_evt_clr_o  = state_clr;
   assign host_evt_clr_o   = host_clr;
endmodule // lsh_dev

// File: hw/lsh_if.sv
// byte-wide access ports of the network side and the local host side
`timescale 1ns/1ps
interface lsh_if;
   import lsh_pkg::*;

   logic [ADDR_W-1:0] net_addr;
   logic [DATA_W-1:0] net_wdata;
   logic              net_wr;
   logic              net_rd;
   logic [DATA_W-1:0] net_rdata;
   logic              net_wr_taken;
   logic [ADDR_W-1:0] hst_addr;
   logic [DATA_W-1:0] hst_wdata;
   logic              hst_wr;
   logic              hst_rd;
   logic [DATA_W-1:0] hst_rdata;

   modport dev (
      input  net_addr, net_wdata, net_wr, net_rd, hst_addr, hst_wdata, hst_wr, hst_rd,
      output net_rdata, net_wr_taken, hst_rdata
   );
   modport ctl (
      output net_addr, net_wdata, net_wr, net_rd, hst_addr, hst_wdata, hst_wr, hst_rd,
      input  net_rdata, net_wr_taken, hst_rdata
   );
endinterface

// File: hw/lsh_pkg.sv
// constants shared by the link and state handshake register bank and its controller
package lsh_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int NPORT  = 3;
   localparam int SW_ADDR_W = 14;

   // byte offsets, low byte at the lower address
   localparam logic [ADDR_W-1:0] OFF_LINK_LO = 12'h110;
   localparam logic [ADDR_W-1:0] OFF_LINK_HI = 12'h111;
   localparam logic [ADDR_W-1:0] OFF_REQ_LO  = 12'h120;
   localparam logic [ADDR_W-1:0] OFF_REQ_HI  = 12'h121;
   localparam logic [ADDR_W-1:0] OFF_STAT_LO = 12'h130;
   localparam logic [ADDR_W-1:0] OFF_STAT_HI = 12'h131;
   localparam logic [ADDR_W-1:0] OFF_CODE_LO = 12'h134;
   localparam logic [ADDR_W-1:0] OFF_CODE_HI = 12'h135;

   // link-status word field positions
   localparam int LNK_HOST_OK = 0;
   localparam int LNK_WDOG    = 1;
   localparam int LNK_ENH     = 2;
   localparam int LNK_PHY0    = 4;
   localparam int LNK_LOOP0   = 8;
   localparam int LNK_COMM0   = 9;
   localparam int LNK_STRIDE  = 2;

   // state request / state status layout: state field 3:0, flag bit 4
   localparam int ST_W    = 5;
   localparam int ST_FLAG = 4;
   localparam logic [ST_W-1:0] REQ_RST  = 5'h01;
   localparam logic [ST_W-1:0] STAT_RST = 5'h01;
   localparam logic [15:0]     CODE_RST = 16'h0000;

   localparam logic [3:0] ST_INIT   = 4'h1;
   localparam logic [3:0] ST_PREOP  = 4'h2;
   localparam logic [3:0] ST_BOOT   = 4'h3;
   localparam logic [3:0] ST_SAFEOP = 4'h4;
   localparam logic [3:0] ST_OP     = 4'h8;

   // controller software map: sw_addr[13:12] selects the target
   localparam logic [1:0] SEL_NET = 2'h0;
   localparam logic [1:0] SEL_HST = 2'h1;
   localparam logic [1:0] SEL_CTL = 2'h2;
   localparam logic [ADDR_W-1:0] CTL_OFF_STAT = 12'h000;
   localparam int CTL_REFUSED = 0;

endpackage

// File: hw/lsh_sync3.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module lsh_sync3 #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            next_level[g] = (s2[g] == s3[g]) ? s3[g] : level_o[g];
         end
         always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               s1[g]      <= 1'b0;
               s2[g]      <= 1'b0;
               s3[g]      <= 1'b0;
               level_o[g] <= 1'b0;
            end else begin
               s1[g]      <= pin_i[g];
               s2[g]      <= s1[g];
               s3[g]      <= s2[g];
               level_o[g] <= next_level[g];
            end
         end
      end
   endgenerate
endmodule // lsh_sync3

// File: verification/lsh_asserts.sv
// checker on the byte ports that join the controller and the register bank
`timescale 1ns/1ps
module lsh_asserts
   import lsh_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   input  wire logic [ADDR_W-1:0] net_addr,
   input  wire logic [DATA_W-1:0] net_wdata,
   input  wire logic              net_wr,
   input  wire logic              net_rd,
   input  wire logic [DATA_W-1:0] net_rdata,
   input  wire logic              net_wr_taken,
   input  wire logic [ADDR_W-1:0] hst_addr,
   input  wire logic [DATA_W-1:0] hst_wdata,
   input  wire logic              hst_wr,
   input  wire logic              hst_rd,
   input  wire logic [DATA_W-1:0] hst_rdata
);
   logic        lock_m;
   logic [4:0]  req_m;
   logic [15:0] code_m;
   logic [7:0]  code_hi;
   logic        net_req;
   logic        hst_req;
   assign net_req = (net_addr == OFF_REQ_LO) || (net_addr == OFF_REQ_HI);
   assign hst_req = (hst_addr == OFF_REQ_LO) || (hst_addr == OFF_REQ_HI);
   assign code_hi = code_m[15:8];
   // lock model only ever relaxes the device, so it holds with mirroring on too
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lock_m <= 1'b0;
         req_m  <= REQ_RST;
         code_m <= CODE_RST;
      end else begin
         if (net_wr_taken) lock_m <= 1'b1;
         else if (hst_rd && hst_req) lock_m <= 1'b0;
         if (net_wr_taken && net_addr == OFF_REQ_LO) req_m <= net_wdata[4:0];
         if (hst_wr && hst_addr == OFF_CODE_LO) code_m[7:0] <= hst_wdata;
         if (hst_wr && hst_addr == OFF_CODE_HI) code_m[15:8] <= hst_wdata;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   AST_NET_IDLE: assert property (!net_rd |=> net_rdata == 8'h00)
      else $error("network read data outside its slot");
   AST_HST_IDLE: assert property (!hst_rd |=> hst_rdata == 8'h00)
      else $error("host read data outside its slot");
   AST_TAKEN_REQ: assert property (net_wr_taken |-> net_wr && net_req)
      else $error("write taken outside the request register");
   AST_UNLOCKED: assert property (net_wr && net_req && !lock_m |-> net_wr_taken)
      else $error("unlocked request write refused");
   AST_REQ_HI: assert property (net_rd && net_addr == OFF_REQ_HI |=> net_rdata == 8'h00)
      else $error("request high byte not zero");
   AST_REQ_BACK: assert property (hst_rd && hst_addr == OFF_REQ_LO |=>
      hst_rdata == {3'h0, $past(req_m)})
      else $error("request low byte differs from last accepted write");
   AST_CODE_BACK: assert property (net_rd && net_addr == OFF_CODE_HI |=>
      net_rdata == $past(code_hi))
      else $error("status code high byte differs from host write");
   AST_LINK_RSVD: assert property (net_rd && net_addr == OFF_LINK_LO |=>
      net_rdata[7] == 1'b0 && net_rdata[3] == 1'b0)
      else $error("reserved link bits set");
   COV_TAKEN: cover property (net_wr_taken);
   COV_REFUSED: cover property (net_wr && net_req && !net_wr_taken);
   COV_CODE: cover property (hst_wr && hst_addr == OFF_CODE_HI);
endmodule // lsh_asserts

// File: verification/testbench.sv
// self-checking bench: controller and register bank joined by their interface
`timescale 1ns/1ps
module testbench;
   import lsh_pkg::*;
   logic ref_clk_i, nrst_i, sw_wr, sw_rd, refused, wdog, cfg_ok, hif_ok, ld, enh, mirror;
   logic [13:0] sw_addr;
   logic [7:0]  sw_wdata, sw_rdata, got;
   logic [2:0]  phy, comm, loop, evt;
   logic [3:0]  req_st, act_st;
   logic        ack, locked, err, pd_en, lclr, sclr, hclr;
   logic [15:0] code, v, e;
   logic [3:0]  st [5] = '{ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_OP};
   int          mismatches, comparisons, cycles, seed;
   lsh_if u_lsh_if ();
   lsh_ctl u_lsh_ctl (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sw_addr_i(sw_addr),
      .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
      .refused_o(refused), .bus(u_lsh_if));
   lsh_dev u_lsh_dev (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(u_lsh_if),
      .phy_link_i(phy), .comm_ok_i(comm), .loop_closed_i(loop), .wdog_reloaded_i(wdog),
      .cfg_loaded_ok_i(cfg_ok), .host_if_ok_i(hif_ok), .cfg_load_done_i(ld),
      .enh_link_cfg_i(enh), .mirror_en_i(mirror), .req_state_o(req_st), .err_ack_o(ack),
      .req_locked_o(locked), .act_state_o(act_st), .err_ind_o(err), .status_code_o(code),
      .pd_access_en_o(pd_en), .link_evt_clr_o(lclr), .state_evt_clr_o(sclr),
      .host_evt_clr_o(hclr));
   lsh_asserts u_lsh_asserts (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .net_addr(u_lsh_if.net_addr), .net_wdata(u_lsh_if.net_wdata), .net_wr(u_lsh_if.net_wr),
      .net_rd(u_lsh_if.net_rd), .net_rdata(u_lsh_if.net_rdata),
      .net_wr_taken(u_lsh_if.net_wr_taken), .hst_addr(u_lsh_if.hst_addr),
      .hst_wdata(u_lsh_if.hst_wdata), .hst_wr(u_lsh_if.hst_wr), .hst_rd(u_lsh_if.hst_rd),
      .hst_rdata(u_lsh_if.hst_rdata));
   always #2 ref_clk_i = ~ref_clk_i;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // run is under two hundred cycles, so this only trips on a hang
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1;
      @(posedge ref_clk_i);
      sw_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [13:0] a);
      @(posedge ref_clk_i);
      sw_addr <= a; sw_rd <= 1'b1;
      @(posedge ref_clk_i);
      sw_rd <= 1'b0;
      #1;
      got = sw_rdata;
      evt = {lclr, sclr, hclr};
   endtask
   function automatic logic [15:0] link_exp(input logic [15:0] x, input logic en);
      link_exp = {2'h0, x[5], x[8], x[4], x[7], x[3], x[6], 1'b0, x[2:0], 1'b0, en, x[9],
         x[10] & x[11]};
   endfunction
   initial begin
      seed = 32'hBA4B; ref_clk_i = 0; nrst_i = 0; sw_wr = 0; sw_rd = 0;
      sw_addr = 0; sw_wdata = 0; {phy, comm, loop} = 0;
      {wdog, cfg_ok, hif_ok, ld, enh, mirror} = 0;
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      rd(14'h0120); chk("req lo", 16'h0001, got);
      rd(14'h0121); chk("req hi", 16'h0000, got);
      rd(14'h0130); chk("stat lo", 16'h0001, got);
      rd(14'h1134); chk("code lo", 16'h0000, got);
      rd(14'h0110); chk("link lo", 16'h0000, got);
      $display("test reset done");
      // enhanced bit must ignore the second load
      @(posedge ref_clk_i); enh <= 1'b1; ld <= 1'b1;
      @(posedge ref_clk_i); enh <= 1'b0; ld <= 1'b0;
      @(posedge ref_clk_i); ld <= 1'b1;
      @(posedge ref_clk_i); ld <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 16'hFFFF : 16'($random(seed));
         @(posedge ref_clk_i);
         phy <= v[2:0]; comm <= v[5:3]; loop <= v[8:6];
         wdog <= v[9]; cfg_ok <= v[10]; hif_ok <= v[11];
         repeat (8) @(posedge ref_clk_i);
         e = link_exp(v, 1'b1);
         rd(14'h0110); chk("link lo", e[7:0], got);
         chk("link clr", 16'h0004, evt);
         chk("pd access", e[0], pd_en);
         rd(14'h0111); chk("link hi", e[15:8], got);
         rd(14'h1110); chk("host link lo", e[7:0], got);
         chk("host no clr", 16'h0000, evt);
      end
      $display("test link word done");
      foreach (st[k]) begin
         wr(14'h0120, {3'h0, k[0], st[k]});
         chk("refused", 16'h0000, refused);
         chk("req", {k[0], st[k]}, {ack, req_st});
         chk("locked", 16'h0001, locked);
         wr(14'h0120, 8'h1F);
         chk("refused", 16'h0001, refused);
         chk("req kept", {k[0], st[k]}, {ack, req_st});
         rd(k[0] ? 14'h1121 : 14'h1120);
         chk("host clr", 16'h0001, evt);
         chk("unlocked", 16'h0000, locked);
         wr(14'h2000, 8'h01);
      end
      wr(14'h0121, 8'hFF); chk("hi locks", 16'h0001, locked);
      rd(14'h1120);
      $display("test request handshake done");
      wr(14'h1130, 8'h12); chk("status", 16'h0012, {err, act_st});
      wr(14'h0130, 8'h04); chk("status kept", 16'h0012, {err, act_st});
      // the controller flags any untaken network write, so clear it before mirroring
      chk("net stat refused", 16'h0001, refused);
      wr(14'h2000, 8'h01);
      rd(14'h0130); chk("stat clr", 16'h0002, evt);
      @(posedge ref_clk_i); mirror <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         v = {11'h0, 1'($random(seed)), st[2 * i + 1]};
         wr(14'h0120, v[7:0]);
         chk("mirror taken", 16'h0000, refused);
         chk("mirror copy", v[4:0], {err, act_st});
      end
      wr(14'h1130, 8'h01); chk("mirror hold", v[4:0], {err, act_st});
      @(posedge ref_clk_i); mirror <= 1'b0;
      rd(14'h1120);
      $display("test status done");
      v = 16'($random(seed));
      wr(14'h1134, v[7:0]); wr(14'h1135, v[15:8]);
      chk("code", v, code);
      rd(14'h0134); chk("code lo", v[7:0], got);
      rd(14'h0135); chk("code hi", v[15:8], got);
      wr(14'h0134, ~v[7:0]); chk("code kept", v, code);
      rd(14'h0150); chk("unmapped", 16'h0000, got);
      $display("test status code done");
      report_and_stop();
   end
endmodule // testbench
